// *** inc/afe_pkg.sv ***
`default_nettype none
package afe_pkg;
   // ==========================================================
   // Converter indices and counts
   localparam int CONV_COUNT = 2;
   localparam int PRIMARY_IDX = 0;
   localparam int AUX_IDX = 1;
   // ==========================================================
   // Result word
   localparam int DATA_W = 16;
   // ==========================================================
   // Excitation pin selection
   localparam logic EXC_PIN_ONE = 1'h0;
   localparam logic EXC_PIN_TWO = 1'h1;
   // ==========================================================
   // Calibration kinds
   localparam logic CAL_OFFSET = 1'h0;
   localparam logic CAL_GAIN = 1'h1;
   // ==========================================================
   // Sequencer states
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_CONVERT,
      SEQ_CALIBRATE
   } afe_seq_type;
endpackage : afe_pkg
`default_nettype wire

// *** inc/afe_conv_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface afe_conv_if #(
   parameter int W = 16
);
   logic modBit;
   logic run;
   logic [W-1:0] rawWord;
   logic rawValid;
   modport seq (output modBit, output run, input rawWord, input rawValid);
   modport flt (input modBit, input run, output rawWord, output rawValid);
endinterface : afe_conv_if
`default_nettype wire

// *** rtl/afe_decimator.sv ***
`timescale 1ns/10ps
`default_nettype none
module afe_decimator #(
   parameter int W = 16
) (
   input wire logic clock,
   input wire logic reset_n,
   afe_conv_if.flt cif
);
   // ==========================================================
   // Window of 2^W-1 modulator samples, ones counted
   localparam logic [W-1:0] LAST_SAMPLE = {{(W-1){1'b1}}, 1'b0};
   logic [W-1:0] sampleCnt_ff;
   logic [W-1:0] onesAcc_ff;
   logic [W-1:0] word_ff;
   logic valid_ff;

   always_ff @(posedge clock) begin
      if (!reset_n || !cif.run) begin
         sampleCnt_ff <= '0;
         onesAcc_ff <= '0;
      end else if (sampleCnt_ff == LAST_SAMPLE) begin
         sampleCnt_ff <= '0;
         onesAcc_ff <= '0;
      end else begin
         sampleCnt_ff <= sampleCnt_ff + W'(1);
         onesAcc_ff <= onesAcc_ff + W'(cif.modBit);
      end
   end

   // ==========================================================
   // Word delivery: duty cycle becomes offset binary word
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         word_ff <= '0;
         valid_ff <= 1'b0;
      end else begin
         valid_ff <= cif.run && (sampleCnt_ff == LAST_SAMPLE);
         if (cif.run && (sampleCnt_ff == LAST_SAMPLE)) begin
            word_ff <= onesAcc_ff + W'(cif.modBit);
         end
      end
   end

   assign cif.rawWord = word_ff;
   assign cif.rawValid = valid_ff;
endmodule : afe_decimator
`default_nettype wire

// *** rtl/afe_front_end_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module afe_front_end_control #(
   parameter int DATA_W = afe_pkg::DATA_W
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [afe_pkg::CONV_COUNT-1:0] modulatorBit,
   input wire logic [afe_pkg::CONV_COUNT-1:0] convStart,
   input wire logic [afe_pkg::CONV_COUNT-1:0] calStart,
   input wire logic [afe_pkg::CONV_COUNT-1:0] calKind,
   input wire logic [afe_pkg::CONV_COUNT-1:0] doneClear,
   input wire logic primaryUnipolar,
   input wire logic auxUnipolar,
   input wire logic primaryExtRefSelect,
   input wire logic auxExtRefSelect,
   input wire logic burnoutEnable,
   input wire logic excSourceOneOn,
   input wire logic excSourceTwoOn,
   input wire logic excCombine,
   input wire logic excCombinePin,
   input wire logic refDiffLow,
   input wire logic refPosOpen,
   input wire logic refNegOpen,
   output logic noValidRefFlag,
   output logic [afe_pkg::CONV_COUNT-1:0] convDoneFlags,
   output logic primaryCalError,
   output logic auxCalError,
   output logic [afe_pkg::CONV_COUNT-1:0] convBusy,
   output logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] convResult,
   output logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] offsetCoef,
   output logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] gainCoef,
   output logic [afe_pkg::CONV_COUNT-1:0] extRefEnable,
   output logic [afe_pkg::CONV_COUNT-1:0] bandgapEnable,
   output logic burnoutSourceOn,
   output logic burnoutSinkOn,
   output logic [1:0] excitationOutOne,
   output logic [1:0] excitationOutTwo
);
   // ==========================================================
   // Output coding from offset binary filter word
   function automatic logic [DATA_W-1:0] codeResult(input logic [DATA_W-1:0] raw, input logic unipolar);
      logic [DATA_W-1:0] coded;
      coded = raw;
      if (unipolar) begin
         if (!raw[DATA_W-1]) begin
            coded = '0;
         end else begin
            coded = {raw[DATA_W-2:0], raw[0]};
         end
      end
      return coded;
   endfunction : codeResult

   // ==========================================================
   // Excitation routing: bit0 source one, bit1 source two
   function automatic logic [1:0] excRoute(input logic pin, input logic oneOn, input logic twoOn,
                                           input logic combine, input logic combinePin);
      logic [1:0] route;
      route = 2'h0;
      if (combine) begin
         if (combinePin == pin) begin
            route = {twoOn, oneOn};
         end
      end else if (pin == afe_pkg::EXC_PIN_ONE) begin
         route = {1'b0, oneOn};
      end else begin
         route = {twoOn, 1'b0};
      end
      return route;
   endfunction : excRoute

   // ==========================================================
   // Control registers
   logic [afe_pkg::CONV_COUNT-1:0] unipolar_ff;
   logic [afe_pkg::CONV_COUNT-1:0] extRef_ff;
   logic [afe_pkg::CONV_COUNT-1:0] bandgap_ff;
   logic burnout_ff;
   logic [1:0] excOne_ff;
   logic [1:0] excTwo_ff;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         unipolar_ff <= '0;
         extRef_ff <= '0;
         bandgap_ff <= '1;
      end else begin
         unipolar_ff <= {auxUnipolar, primaryUnipolar};
         extRef_ff <= {auxExtRefSelect, primaryExtRefSelect};
         bandgap_ff <= ~{auxExtRefSelect, primaryExtRefSelect};
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         burnout_ff <= 1'b0;
      end else begin
         burnout_ff <= burnoutEnable;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         excOne_ff <= 2'h0;
         excTwo_ff <= 2'h0;
      end else begin
         excOne_ff <= excRoute(afe_pkg::EXC_PIN_ONE, excSourceOneOn, excSourceTwoOn,
                               excCombine, excCombinePin);
         excTwo_ff <= excRoute(afe_pkg::EXC_PIN_TWO, excSourceOneOn, excSourceTwoOn,
                               excCombine, excCombinePin);
      end
   end

   // ==========================================================
   // Reference detect
   logic noRef_ff;

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         noRef_ff <= 1'b0;
      end else begin
         noRef_ff <= refDiffLow || refPosOpen || refNegOpen;
      end
   end

   // ==========================================================
   // Per-converter sequencer
   logic [afe_pkg::CONV_COUNT-1:0] done_ff;
   logic [afe_pkg::CONV_COUNT-1:0] calErr_ff;
   logic [afe_pkg::CONV_COUNT-1:0] busy_ff;
   logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] result_ff;
   logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] offset_ff;
   logic [afe_pkg::CONV_COUNT-1:0][DATA_W-1:0] gain_ff;

   for (genvar c = 0; c < afe_pkg::CONV_COUNT; c++) begin : g_conv
      afe_conv_if #(.W(DATA_W)) cif ();
      afe_pkg::afe_seq_type state_ff;
      logic kind_ff;
      logic refLost_ff;

      afe_decimator #(.W(DATA_W)) u_decimator (
         .clock(clock),
         .reset_n(reset_n),
         .cif(cif.flt)
      );

      assign cif.modBit = modulatorBit[c];
      assign cif.run = (state_ff != afe_pkg::SEQ_IDLE);

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            state_ff <= afe_pkg::SEQ_IDLE;
            kind_ff <= afe_pkg::CAL_OFFSET;
         end else begin
            case (state_ff)
               afe_pkg::SEQ_IDLE: begin
                  if (calStart[c]) begin
                     state_ff <= afe_pkg::SEQ_CALIBRATE;
                     kind_ff <= calKind[c];
                  end else if (convStart[c]) begin
                     state_ff <= afe_pkg::SEQ_CONVERT;
                  end
               end
               default: begin
                  if (cif.rawValid) begin
                     state_ff <= afe_pkg::SEQ_IDLE;
                  end
               end
            endcase
         end
      end

      // Reference loss seen at any point of the running cycle
      always_ff @(posedge clock) begin
         if (!reset_n || state_ff == afe_pkg::SEQ_IDLE) begin
            refLost_ff <= 1'b0;
         end else if (noRef_ff) begin
            refLost_ff <= 1'b1;
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            result_ff[c] <= '0;
         end else if (state_ff == afe_pkg::SEQ_CONVERT && cif.rawValid) begin
            if (refLost_ff || noRef_ff) begin
               result_ff[c] <= '1;
            end else begin
               result_ff[c] <= codeResult(cif.rawWord, unipolar_ff[c]);
            end
         end
      end

      // Coefficients taken at the coded calibration point
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            offset_ff[c] <= '0;
            gain_ff[c] <= '0;
         end else if (state_ff == afe_pkg::SEQ_CALIBRATE && cif.rawValid && !(refLost_ff || noRef_ff)) begin
            if (kind_ff == afe_pkg::CAL_GAIN) begin
               gain_ff[c] <= codeResult(cif.rawWord, unipolar_ff[c]);
            end else begin
               offset_ff[c] <= codeResult(cif.rawWord, unipolar_ff[c]);
            end
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            calErr_ff[c] <= 1'b0;
         end else if (state_ff == afe_pkg::SEQ_CALIBRATE && cif.rawValid && (refLost_ff || noRef_ff)) begin
            calErr_ff[c] <= 1'b1;
         end else if (state_ff == afe_pkg::SEQ_IDLE && calStart[c]) begin
            calErr_ff[c] <= 1'b0;
         end
      end

      // Done flag: set wins over clear
      always_ff @(posedge clock) begin
         if (!reset_n) begin
            done_ff[c] <= 1'b0;
         end else if (state_ff != afe_pkg::SEQ_IDLE && cif.rawValid) begin
            done_ff[c] <= 1'b1;
         end else if (doneClear[c]) begin
            done_ff[c] <= 1'b0;
         end
      end

      always_ff @(posedge clock) begin
         if (!reset_n) begin
            busy_ff[c] <= 1'b0;
         end else begin
            busy_ff[c] <= (state_ff == afe_pkg::SEQ_IDLE) ? (calStart[c] || convStart[c]) : !cif.rawValid;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign noValidRefFlag = noRef_ff;
   assign convDoneFlags = done_ff;
   assign primaryCalError = calErr_ff[afe_pkg::PRIMARY_IDX];
   assign auxCalError = calErr_ff[afe_pkg::AUX_IDX];
   assign convBusy = busy_ff;
   assign convResult = result_ff;
   assign offsetCoef = offset_ff;
   assign gainCoef = gain_ff;
   assign extRefEnable = extRef_ff;
   assign bandgapEnable = bandgap_ff;
   assign burnoutSourceOn = burnout_ff;
   assign burnoutSinkOn = burnout_ff;
   assign excitationOutOne = excOne_ff;
   assign excitationOutTwo = excTwo_ff;
endmodule : afe_front_end_control
`default_nettype wire

// *** verif/afe_front_end_control_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module afe_front_end_control_properties #(
   parameter int DATA_W = 4
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [1:0] convStart,
   input wire logic [1:0] calStart,
   input wire logic burnoutEnable,
   input wire logic refDiffLow,
   input wire logic refPosOpen,
   input wire logic refNegOpen,
   input wire logic noValidRefFlag,
   input wire logic [1:0] convDoneFlags,
   input wire logic auxCalError,
   input wire logic [1:0] convBusy,
   input wire logic [1:0][DATA_W-1:0] convResult,
   input wire logic [1:0][DATA_W-1:0] gainCoef,
   input wire logic [1:0] extRefEnable,
   input wire logic [1:0] bandgapEnable,
   input wire logic burnoutSourceOn,
   input wire logic burnoutSinkOn
);
   localparam int WIN = (1 << DATA_W) - 1;
   // ==========
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   // Kind of the run in progress on the primary converter
   logic calRun0_ff;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         calRun0_ff <= 1'b0;
      end else if (!convBusy[0] && (calStart[0] || convStart[0])) begin
         calRun0_ff <= calStart[0];
      end
   end
   burnout_follow_a: assert property ($past(reset_n) |->
      burnoutSourceOn == $past(burnoutEnable) && burnoutSinkOn == burnoutSourceOn) else $error("burnout wrong");
   ref_flag_a: assert property ($past(reset_n) |->
      noValidRefFlag == $past(refDiffLow || refPosOpen || refNegOpen)) else $error("ref flag wrong");
   ref_compl_a: assert property (bandgapEnable == ~extRefEnable) else $error("ref enables clash");
   conv_start_a: assert property (!convBusy[0] && convStart[0] && !calStart[0] |=> convBusy[0])
      else $error("start not taken");
   primary_done_a: assert property ($rose(convBusy[0]) |->
      ##WIN convBusy[0] ##1 !convBusy[0] && convDoneFlags[0]) else $error("primary done late");
   aux_done_a: assert property ($rose(convBusy[1]) |->
      ##WIN convBusy[1] ##1 !convBusy[1] && convDoneFlags[1]) else $error("aux done late");
   forced_ones_a: assert property ($fell(convBusy[0]) && $past(noValidRefFlag) && !calRun0_ff |-> &convResult[0])
      else $error("result not forced");
   cal_block_a: assert property ($rose(auxCalError) |-> $stable(gainCoef[1])) else $error("coef written");
   cover property ($rose(convDoneFlags[0]));
   cover property ($rose(noValidRefFlag));
   cover property ($fell(convBusy[1]) && auxCalError);
endmodule : afe_front_end_control_properties
bind afe_front_end_control afe_front_end_control_properties #(.DATA_W(DATA_W)) i_props (.clock, .reset_n,
   .convStart, .calStart, .burnoutEnable, .refDiffLow, .refPosOpen, .refNegOpen, .noValidRefFlag, .convDoneFlags,
   .auxCalError, .convBusy, .convResult, .gainCoef, .extRefEnable, .bandgapEnable, .burnoutSourceOn, .burnoutSinkOn);
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb;
   localparam int DW = 4;
   localparam int WIN = (1 << DW) - 1;
   logic clock = 1'h0, reset_n = 1'h0;
   logic [1:0] modulatorBit = 2'h0, convStart = 2'h0, calStart = 2'h0, calKind = 2'h0, doneClear = 2'h0;
   logic primaryUnipolar = 1'h0, auxUnipolar = 1'h0, primaryExtRefSelect = 1'h0, auxExtRefSelect = 1'h0;
   logic burnoutEnable = 1'h0, excSourceOneOn = 1'h0, excSourceTwoOn = 1'h0, excCombine = 1'h0;
   logic excCombinePin = 1'h0, refDiffLow = 1'h0, refPosOpen = 1'h0, refNegOpen = 1'h0;
   logic noValidRefFlag, primaryCalError, auxCalError, burnoutSourceOn, burnoutSinkOn;
   logic [1:0] convDoneFlags, convBusy, extRefEnable, bandgapEnable, excitationOutOne, excitationOutTwo;
   logic [1:0][DW-1:0] convResult, offsetCoef, gainCoef;
   int error_cnt = 0, compares = 0, cycles = 0;
   afe_front_end_control #(.DATA_W(DW)) i_afe_front_end_control (.clock, .reset_n, .modulatorBit, .convStart,
      .calStart, .calKind, .doneClear, .primaryUnipolar, .auxUnipolar, .primaryExtRefSelect, .auxExtRefSelect,
      .burnoutEnable, .excSourceOneOn, .excSourceTwoOn, .excCombine, .excCombinePin, .refDiffLow, .refPosOpen,
      .refNegOpen, .noValidRefFlag, .convDoneFlags, .primaryCalError, .auxCalError, .convBusy, .convResult,
      .offsetCoef, .gainCoef, .extRefEnable, .bandgapEnable, .burnoutSourceOn, .burnoutSinkOn,
      .excitationOutOne, .excitationOutTwo);
   always #2 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         $display("[ERR] %0t timeout", $time);
         summarize();
      end
   end
   // ==========
   // Helpers
   task automatic tick();
      @(negedge clock);
   endtask : tick
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic conv(input int i, input int k, input logic cal, input logic kind, input logic lose);
      int n;
      doneClear[i] = 1'h1;
      tick();
      doneClear[i] = 1'h0;
      calStart[i] = cal;
      calKind[i] = kind;
      convStart[i] = !cal;
      tick();
      calStart[i] = 1'h0;
      convStart[i] = 1'h0;
      for (n = 0; n < WIN; n++) begin
         modulatorBit[i] = n < k;
         refDiffLow = lose && n > 4;
         tick();
      end
      modulatorBit[i] = 1'h0;
      n = 0;
      while (convDoneFlags[i] !== 1'h1 && n < 9) begin
         tick();
         n++;
      end
      refDiffLow = 1'h0;
      check(8'(n), 8'h01);
   endtask : conv
   // ==========
   // Scenarios
   task automatic t_ctrl();
      logic [4:0] j;
      burnoutEnable = 1'h1;
      tick();
      check(8'({burnoutSourceOn, burnoutSinkOn}), 8'h03);
      burnoutEnable = 1'h0;
      tick();
      check(8'({burnoutSourceOn, burnoutSinkOn}), 8'h00);
      for (j = 0; j < 4; j++) begin
         {auxExtRefSelect, primaryExtRefSelect} = j[1:0];
         tick();
         check(8'({extRefEnable, bandgapEnable}), 8'({j[1:0], ~j[1:0]}));
      end
      for (j = 0; j < 16; j++) begin
         {excCombinePin, excCombine, excSourceTwoOn, excSourceOneOn} = j[3:0];
         tick();
         check(8'({excitationOutOne, excitationOutTwo}), 8'(!j[2] ? {1'h0, j[0], j[1], 1'h0} :
            j[3] ? {2'h0, j[1], j[0]} : {j[1], j[0], 2'h0}));
      end
   endtask : t_ctrl
   task automatic t_coding();
      int ks[4] = '{0, 8, 12, 15};
      logic [3:0] bip[4] = '{4'h0, 4'h8, 4'hC, 4'hF};
      logic [3:0] uni[4] = '{4'h0, 4'h0, 4'h8, 4'hF};
      int i, u, j;
      for (u = 0; u < 2; u++) begin
         primaryUnipolar = 1'(u);
         auxUnipolar = 1'(1 - u);
         for (j = 0; j < 8; j++) begin
            i = j % 2;
            conv(i, ks[j / 2], 1'h0, 1'h0, 1'h0);
            check(8'(convResult[i]), 8'((i != u) ? uni[j / 2] : bip[j / 2]));
         end
      end
   endtask : t_coding
   task automatic t_noref();
      int j;
      conv(0, 3, 1'h0, 1'h0, 1'h1);
      check(8'(convResult[0]), 8'h0F);
      check(8'(noValidRefFlag), 8'h01);
      tick();
      check(8'(noValidRefFlag), 8'h00);
      for (j = 0; j < 3; j++) begin
         {refNegOpen, refPosOpen, refDiffLow} = 3'(1 << j);
         tick();
         check(8'(noValidRefFlag), 8'h01);
         {refNegOpen, refPosOpen, refDiffLow} = 3'h0;
         tick();
         check(8'(noValidRefFlag), 8'h00);
      end
   endtask : t_noref
   task automatic t_cal();
      auxUnipolar = 1'h1;
      conv(1, 15, 1'h1, 1'h1, 1'h0);
      conv(1, 0, 1'h1, 1'h0, 1'h0);
      check(8'({gainCoef[1], offsetCoef[1]}), 8'hF0);
      check(8'(auxCalError), 8'h00);
      conv(1, 12, 1'h1, 1'h1, 1'h1);
      check(8'({gainCoef[1], auxCalError}), 8'h1F);
      check(8'(primaryCalError), 8'h00);
      conv(1, 0, 1'h1, 1'h0, 1'h0);
      check(8'(auxCalError), 8'h00);
      primaryUnipolar = 1'h1;
      conv(0, 12, 1'h1, 1'h0, 1'h0);
      check(8'(offsetCoef[0]), 8'h08);
      check(8'(primaryCalError), 8'h00);
   endtask : t_cal
   task automatic summarize();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (8) tick();
      reset_n = 1'h1;
      check(8'({bandgapEnable, convBusy}), 8'h0C);
      t_ctrl();
      t_coding();
      t_noref();
      t_cal();
      summarize();
   end
endmodule : tb
`default_nettype wire
